// ===== design/amp_control_register_bank.v
`timescale 1ns/100ps
`include "amp_control_map.vh"
// Operation
// - twenty-one writable registers plus one read-only status, 00h-15h, 16 bits
// - device control at 00h is read/write, resets to 0000h
// - input one serial config 01h resets 0a18h, pcm format 02h 0007h
// - input two serial config 03h resets 0a18h, pcm format 04h 0007h
// - equalizer coefficient words 05h-0eh carry their listed reset values
// - bypass 0fh resets 0093h, compressor 10h resets 92bah
// - tone 11h resets 12a5h, dc block filter 12h resets 0004h
// - gain control 13h is read/write, resets 10bdh
// - mute and limiter 14h is read/write, resets 0000h
// - status 15h is read-only; host writes to it are ignored
// - control bit 4 picks serial input one (0) or two (1)
// - bit 0 low means power-down; when high, bit 3 picks off or amplifier
// - writing 1 to control bit 1 resets the device; bit reads 0
// - registers move as byte pairs, high byte first; host writes whole pairs
// - each completed written pair advances the register pointer by one
// - reads send high then low byte; ack advances, nack releases bus
module amp_control_register_bank (
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_r,
  output reg sda_oe_n_r,
  input wire adsel1,
  input wire adsel2,
  input wire [15:0] status_in,
  output reg input_sel_r,
  output reg amp_run_choice_r,
  output reg wake_request_r,
  output reg amp_enabled_r,
  output reg [15:0] active_serial_cfg_r,
  output reg [15:0] active_pcm_fmt_r,
  output reg soft_reset_pulse_r,
  output reg reg_write_pulse_r,
  output reg [4:0] reg_write_index_r,
  output reg bus_busy_r,
  output wire [`NUM_CTRL_REGS*`REG_WIDTH-1:0] reg_image
);

  // one-hot transfer states
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_DEV = 8'h02;
  localparam [7:0] S_REG = 8'h04;
  localparam [7:0] S_WR = 8'h08;
  localparam [7:0] S_ACK = 8'h10;
  localparam [7:0] S_TX = 8'h20;
  localparam [7:0] S_RACK = 8'h40;
  localparam [7:0] S_WAIT = 8'h80;

  reg [15:0] regs_r [0:`NUM_CTRL_REGS-1];
  reg [7:0] state_r;
  reg [7:0] after_ack_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] tx_shift_r;
  reg [15:0] tx_word_r;
  reg [7:0] msb_hold_r;
  reg [4:0] ptr_r;
  reg hi_next_r;
  reg ack_seen_r;
  integer i;

  wire ev_start;
  wire ev_stop;
  wire ev_rise;
  wire ev_fall;
  wire sda_s;
  wire [15:0] wr_word;
  wire byte_done;

  i2c_line_events line_ev (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_r(ev_start),
    .stop_r(ev_stop),
    .scl_rise_r(ev_rise),
    .scl_fall_r(ev_fall),
    .sda_r(sda_s)
  );

  assign wr_word = {msb_hold_r, shift_r}; // high byte came first
  assign byte_done = ev_fall & (bit_cnt_r == `BYTE_BITS);

  // register image for the sound path, straight from the flops
  genvar g;
  generate
    for (g = 0; g < `NUM_CTRL_REGS; g = g + 1) begin : img
      assign reg_image[g*`REG_WIDTH +: `REG_WIDTH] = regs_r[g];
    end
  endgenerate

  // default of each control register
  function [15:0] reg_default;
    input [4:0] idx;
    begin
      case (idx)
        `REG_CTRL: reg_default = `RST_CTRL;
        `REG_IN1_SERIAL: reg_default = `RST_SERIAL;
        `REG_IN1_PCM: reg_default = `RST_PCM;
        `REG_IN2_SERIAL: reg_default = `RST_SERIAL;
        `REG_IN2_PCM: reg_default = `RST_PCM;
        `REG_EQ_A_LO: reg_default = `RST_EQ_A_LO;
        `REG_EQ_A_HI: reg_default = `RST_EQ_A_HI;
        `REG_EQ_B_LO: reg_default = `RST_EQ_B_LO;
        `REG_EQ_B_HI: reg_default = `RST_EQ_B_HI;
        `REG_EQ_C_LO: reg_default = `RST_EQ_C_LO;
        `REG_EQ_C_HI: reg_default = `RST_EQ_C_HI;
        `REG_EQ_D_LO: reg_default = `RST_EQ_D_LO;
        `REG_EQ_D_HI: reg_default = `RST_EQ_D_HI;
        `REG_EQ_E_LO: reg_default = `RST_EQ_E_LO;
        `REG_EQ_E_HI: reg_default = `RST_EQ_E_HI;
        `REG_BYPASS: reg_default = `RST_BYPASS;
        `REG_COMPRESSOR: reg_default = `RST_COMPRESSOR;
        `REG_TONE: reg_default = `RST_TONE;
        `REG_DC_BLOCK: reg_default = `RST_DC_BLOCK;
        `REG_GAIN: reg_default = `RST_GAIN;
        `REG_MUTE_LIMIT: reg_default = `RST_MUTE_LIMIT;
        default: reg_default = `RST_UNMAPPED;
      endcase
    end
  endfunction

  // word seen by a read at a pointer; beyond the map reads zero
  function [15:0] word_at;
    input [4:0] idx;
    begin
      if (idx < `REG_STATUS) begin
        word_at = regs_r[idx];
      end else if (idx == `REG_STATUS) begin
        word_at = status_in;
      end else begin
        word_at = `RST_UNMAPPED;
      end
    end
  endfunction

  // msb for the line now, the other seven bits queued behind it
  function [8:0] hi_byte_load;
    input [15:0] w;
    begin
      hi_byte_load = {w[15:8], 1'b0};
    end
  endfunction

  // transfer engine and register file share one process so that the
  // pointer, the data and the soft reset never race each other
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < `NUM_CTRL_REGS; i = i + 1) begin
        regs_r[i] <= reg_default(i[4:0]);
      end
      state_r <= S_IDLE;
      after_ack_r <= S_IDLE;
      bit_cnt_r <= `BIT_CNT_ZERO;
      shift_r <= 8'h00;
      tx_shift_r <= 8'h00;
      tx_word_r <= 16'h0000;
      msb_hold_r <= 8'h00;
      ptr_r <= `REG_CTRL;
      hi_next_r <= 1'b1;
      ack_seen_r <= 1'b0;
      sda_out_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      soft_reset_pulse_r <= 1'b0;
      reg_write_pulse_r <= 1'b0;
      reg_write_index_r <= `REG_CTRL;
      bus_busy_r <= 1'b0;
    end else begin
      soft_reset_pulse_r <= 1'b0;
      reg_write_pulse_r <= 1'b0;
      sda_out_r <= 1'b0; // open drain: only ever pulls low
      if (ev_start) begin
        // start or repeated start always restarts address phase
        state_r <= S_DEV;
        bit_cnt_r <= `BIT_CNT_ZERO;
        sda_oe_n_r <= 1'b1;
        bus_busy_r <= 1'b1;
      end else if (ev_stop) begin
        state_r <= S_IDLE;
        sda_oe_n_r <= 1'b1;
        bus_busy_r <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            sda_oe_n_r <= 1'b1;
          end
          S_DEV, S_REG, S_WR: begin
            // sample on the rising clock edge
            if (ev_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + `BIT_CNT_ONE;
            end
            if (byte_done) begin
              bit_cnt_r <= `BIT_CNT_ZERO;
              if (state_r == S_DEV) begin
                if (shift_r[7:1] == {`DEV_ADDR_FIXED, adsel2, adsel1}) begin
                  sda_oe_n_r <= 1'b0;
                  state_r <= S_ACK;
                  after_ack_r <= shift_r[0] ? S_TX : S_REG;
                  hi_next_r <= 1'b1;
                end else begin
                  // another slave is addressed; sit out until the next start or stop
                  state_r <= S_WAIT;
                end
              end else if (state_r == S_REG) begin
                ptr_r <= shift_r[4:0];
                hi_next_r <= 1'b1;
                sda_oe_n_r <= 1'b0;
                state_r <= S_ACK;
                after_ack_r <= S_WR;
              end else begin
                sda_oe_n_r <= 1'b0;
                state_r <= S_ACK;
                after_ack_r <= S_WR;
                if (hi_next_r) begin
                  // a lone high byte is held, never written
                  msb_hold_r <= shift_r;
                  hi_next_r <= 1'b0;
                end else begin
                  hi_next_r <= 1'b1;
                  ptr_r <= ptr_r + `REG_PTR_STEP;
                  if ((ptr_r == `REG_CTRL) &&
                      wr_word[`CTRL_SOFT_RST_BIT]) begin
                    // soft reset wins over the rest of the word, so
                    // the trigger bit itself is never stored
                    for (i = 0; i < `NUM_CTRL_REGS; i = i + 1) begin
                      regs_r[i] <= reg_default(i[4:0]);
                    end
                    soft_reset_pulse_r <= 1'b1;
                  end else if (ptr_r == `REG_CTRL) begin
                    regs_r[`REG_CTRL] <= wr_word & `CTRL_WR_MASK;
                    reg_write_pulse_r <= 1'b1;
                    reg_write_index_r <= ptr_r;
                  end else if (ptr_r < `REG_STATUS) begin
                    regs_r[ptr_r] <= wr_word;
                    reg_write_pulse_r <= 1'b1;
                    reg_write_index_r <= ptr_r;
                  end
                  // status and unmapped pointers drop the word
                end
              end
            end
          end
          S_ACK: begin
            // hold the acknowledge through the ninth clock
            if (ev_fall) begin
              if (after_ack_r == S_TX) begin
                tx_word_r <= word_at(ptr_r);
                // high byte leads, msb goes out at once
                {sda_oe_n_r, tx_shift_r} <= hi_byte_load(word_at(ptr_r));
                bit_cnt_r <= `BIT_CNT_ONE;
                hi_next_r <= 1'b0;
                state_r <= S_TX;
              end else begin
                sda_oe_n_r <= 1'b1;
                bit_cnt_r <= `BIT_CNT_ZERO;
                state_r <= after_ack_r;
              end
            end
          end
          S_TX: begin
            // change data only while scl is low
            if (ev_fall) begin
              if (bit_cnt_r < `BYTE_BITS) begin
                sda_oe_n_r <= tx_shift_r[7];
                tx_shift_r <= {tx_shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + `BIT_CNT_ONE;
              end else begin
                sda_oe_n_r <= 1'b1; // let the host answer
                ack_seen_r <= 1'b0;
                state_r <= S_RACK;
              end
            end
          end
          S_RACK: begin
            if (ev_rise) begin
              if (sda_s) begin
                state_r <= S_WAIT; // nack frees the bus
              end else begin
                ack_seen_r <= 1'b1;
                if (hi_next_r) begin
                  ptr_r <= ptr_r + `REG_PTR_STEP;
                end
              end
            end
            if (ev_fall && ack_seen_r) begin
              bit_cnt_r <= `BIT_CNT_ONE;
              state_r <= S_TX;
              if (hi_next_r) begin
                // word latched whole so its two bytes stay coherent
                tx_word_r <= word_at(ptr_r);
                {sda_oe_n_r, tx_shift_r} <= hi_byte_load(word_at(ptr_r));
                hi_next_r <= 1'b0;
              end else begin
                sda_oe_n_r <= tx_word_r[7]; // low byte second
                tx_shift_r <= {tx_word_r[6:0], 1'b0};
                hi_next_r <= 1'b1;
              end
            end
          end
          S_WAIT: begin
            sda_oe_n_r <= 1'b1;
          end
          default: begin
            state_r <= S_IDLE;
            sda_oe_n_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // decoded control lags the register by one cycle, kept in flops so
  // downstream power logic never sees a decode glitch
  always @(posedge clk) begin
    if (rst) begin
      input_sel_r <= 1'b0;
      amp_run_choice_r <= 1'b0;
      wake_request_r <= 1'b0;
      amp_enabled_r <= 1'b0;
      active_serial_cfg_r <= `RST_SERIAL;
      active_pcm_fmt_r <= `RST_PCM;
    end else begin
      input_sel_r <= regs_r[`REG_CTRL][`CTRL_INSEL_BIT];
      amp_run_choice_r <= regs_r[`REG_CTRL][`CTRL_RUN_BIT];
      wake_request_r <= regs_r[`REG_CTRL][`CTRL_WAKE_BIT];
      // run choice only counts once out of power-down
      amp_enabled_r <= regs_r[`REG_CTRL][`CTRL_WAKE_BIT] &
                       regs_r[`REG_CTRL][`CTRL_RUN_BIT];
      if (regs_r[`REG_CTRL][`CTRL_INSEL_BIT]) begin
        active_serial_cfg_r <= regs_r[`REG_IN2_SERIAL];
        active_pcm_fmt_r <= regs_r[`REG_IN2_PCM];
      end else begin
        active_serial_cfg_r <= regs_r[`REG_IN1_SERIAL];
        active_pcm_fmt_r <= regs_r[`REG_IN1_PCM];
      end
    end
  end

endmodule // amp_control_register_bank

// ===== design/amp_control_map.vh
`ifndef AMP_CONTROL_MAP_VH
`define AMP_CONTROL_MAP_VH

// bus slave address: upper five bits fixed, low two from strap pins
`define DEV_ADDR_FIXED 5'h1b

// byte framing
`define BYTE_BITS 4'h8
`define BIT_CNT_ZERO 4'h0
`define BIT_CNT_ONE 4'h1

// register indices
`define REG_WIDTH 16
`define NUM_CTRL_REGS 21
`define REG_CTRL 5'h00
`define REG_IN1_SERIAL 5'h01
`define REG_IN1_PCM 5'h02
`define REG_IN2_SERIAL 5'h03
`define REG_IN2_PCM 5'h04
`define REG_EQ_A_LO 5'h05
`define REG_EQ_A_HI 5'h06
`define REG_EQ_B_LO 5'h07
`define REG_EQ_B_HI 5'h08
`define REG_EQ_C_LO 5'h09
`define REG_EQ_C_HI 5'h0a
`define REG_EQ_D_LO 5'h0b
`define REG_EQ_D_HI 5'h0c
`define REG_EQ_E_LO 5'h0d
`define REG_EQ_E_HI 5'h0e
`define REG_BYPASS 5'h0f
`define REG_COMPRESSOR 5'h10
`define REG_TONE 5'h11
`define REG_DC_BLOCK 5'h12
`define REG_GAIN 5'h13
`define REG_MUTE_LIMIT 5'h14
`define REG_STATUS 5'h15
`define REG_PTR_STEP 5'h01

// reset values
`define RST_CTRL 16'h0000
`define RST_SERIAL 16'h0a18
`define RST_PCM 16'h0007
`define RST_EQ_A_LO 16'h59dd
`define RST_EQ_A_HI 16'hc63e
`define RST_EQ_B_LO 16'h651a
`define RST_EQ_B_HI 16'he53e
`define RST_EQ_C_LO 16'h4616
`define RST_EQ_C_HI 16'hd33e
`define RST_EQ_D_LO 16'h4df3
`define RST_EQ_D_HI 16'hea3e
`define RST_EQ_E_LO 16'h5ee0
`define RST_EQ_E_HI 16'hf93e
`define RST_BYPASS 16'h0093
`define RST_COMPRESSOR 16'h92ba
`define RST_TONE 16'h12a5
`define RST_DC_BLOCK 16'h0004
`define RST_GAIN 16'h10bd
`define RST_MUTE_LIMIT 16'h0000
`define RST_UNMAPPED 16'h0000

// device control fields
`define CTRL_WAKE_BIT 0
`define CTRL_SOFT_RST_BIT 1
`define CTRL_RUN_BIT 3
`define CTRL_INSEL_BIT 4
`define CTRL_WR_MASK 16'h0019

`endif

// ===== design/i2c_line_events.v
`timescale 1ns/100ps
// turns sampled scl/sda levels into one-cycle bus events
module i2c_line_events (
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg start_r,
  output reg stop_r,
  output reg scl_rise_r,
  output reg scl_fall_r,
  output reg sda_r
);

  reg scl_prev_r;
  reg sda_prev_r;

  // lines idle high, so reset to high to avoid a false edge
  always @(posedge clk) begin
    if (rst) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      scl_rise_r <= 1'b0;
      scl_fall_r <= 1'b0;
      sda_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_in;
      sda_prev_r <= sda_in;
      sda_r <= sda_in;
      // sda moving while scl stays high frames a transfer
      start_r <= scl_in & scl_prev_r & sda_prev_r & ~sda_in;
      stop_r <= scl_in & scl_prev_r & ~sda_prev_r & sda_in;
      scl_rise_r <= scl_in & ~scl_prev_r;
      scl_fall_r <= ~scl_in & scl_prev_r;
    end
  end

endmodule // i2c_line_events

// ===== sim/amp_control_register_bank_props.sv
`timescale 1ns/100ps
`include "amp_control_map.vh"
// watches bus pins and the register image from outside the bank
module amp_control_register_bank_props (
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_oe_n_r,
  input wire input_sel_r,
  input wire amp_enabled_r,
  input wire [15:0] active_serial_cfg_r,
  input wire soft_reset_pulse_r,
  input wire reg_write_pulse_r,
  input wire [4:0] reg_write_index_r,
  input wire bus_busy_r,
  input wire [`NUM_CTRL_REGS*`REG_WIDTH-1:0] reg_image
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // framing events as the pins show them
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  sequence s_pull_held;
    !sda_oe_n_r [*4];
  endsequence
  a_busy_on_start: assert property (s_start |-> ##[1:4] bus_busy_r)
    else $error("busy not raised after start");
  a_idle_on_stop: assert property (s_stop |-> ##[1:4] !bus_busy_r)
    else $error("busy not dropped after stop");
  // data may only move while scl is low, or it would fake a start/stop
  a_drive_low_phase: assert property ($changed(sda_oe_n_r) |-> !scl_in)
    else $error("sda drive changed with scl high");
  a_pull_holds: assert property ($fell(sda_oe_n_r) |-> s_pull_held)
    else $error("sda pull too short");
  a_reset_values: assert property ($fell(rst) |->
    reg_image[31:16] == `RST_SERIAL && reg_image[319:304] == `RST_GAIN)
    else $error("defaults missing after reset");
  a_image_quiet: assert property (!reg_write_pulse_r
    && !soft_reset_pulse_r |-> $stable(reg_image))
    else $error("register image changed without a write");
  a_status_ro: assert property (reg_write_pulse_r |->
    reg_write_index_r < 5'h15)
    else $error("write stored outside the control range");
  a_ctrl_reserved: assert property (reg_image[15:5] == 11'h000
    && reg_image[2:1] == 2'b00)
    else $error("reserved or reset control bit set");
  a_input_route: assert property (input_sel_r == $past(reg_image[4])
    && active_serial_cfg_r == ($past(reg_image[4]) ?
    $past(reg_image[63:48]) : $past(reg_image[31:16])))
    else $error("wrong serial input routed");
  a_amp_state: assert property (amp_enabled_r ==
    ($past(reg_image[0]) && $past(reg_image[3])))
    else $error("amplifier state wrong");
  a_soft_defaults: assert property (soft_reset_pulse_r |-> ##[0:1]
    (reg_image[15:0] == 16'h0000 && reg_image[175:160] == `RST_EQ_C_HI))
    else $error("soft reset left registers changed");
  a_soft_alone: assert property (soft_reset_pulse_r |->
    !reg_write_pulse_r ##1 !soft_reset_pulse_r)
    else $error("soft reset pulse malformed");
endmodule // amp_control_register_bank_props
bind amp_control_register_bank amp_control_register_bank_props u_props (
  .clk, .rst, .scl_in, .sda_in, .sda_oe_n_r, .input_sel_r, .amp_enabled_r,
  .active_serial_cfg_r, .soft_reset_pulse_r, .reg_write_pulse_r,
  .reg_write_index_r, .bus_busy_r, .reg_image);

// ===== sim/i2c_host_model.sv
`timescale 1ns/100ps
// bus master: drives scl and pulls the open-drain data line
module i2c_host_model (
  input wire clk,
  input wire sda,
  output reg scl,
  output reg sda_drv
);
  integer half = 6; // clk cycles per scl phase; raised for a slow host
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // steps just past a clock edge so the device samples settled levels
  task wt(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // serves as repeated start too, entered with scl low
  task start;
    wt(half / 2);
    sda_drv = 1'b1;
    wt(half - half / 2);
    scl = 1'b1;
    wt(half);
    sda_drv = 1'b0;
    wt(half);
    scl = 1'b0;
  endtask
  task stop;
    wt(half / 2);
    sda_drv = 1'b0;
    wt(half - half / 2);
    scl = 1'b1;
    wt(half);
    sda_drv = 1'b1;
    wt(half);
  endtask
  // data changes mid low phase, read at the end of the high phase
  task xbit(input b, output r);
    wt(half / 2);
    sda_drv = b;
    wt(half - half / 2);
    scl = 1'b1;
    wt(half);
    r = sda;
    scl = 1'b0;
  endtask
  task wbyte(input [7:0] d, output ak);
    reg r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ak = ~r;
  endtask
  // ack asks for the next byte, nack ends the burst
  task rbyte(output [7:0] d, input ak);
    reg r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(~ak, r);
  endtask
endmodule // i2c_host_model

// ===== sim/amp_control_register_bank_tb.sv
`timescale 1ns/100ps
module amp_control_register_bank_tb;
  logic clk, rst, adsel1, adsel2;
  logic [15:0] status_in;
  wire scl, h_sda, sda_out, oe_n, in_sel, run, wake, amp_en, sr_p, wr_p, busy;
  wire [15:0] ser, pcm;
  wire [4:0] wr_i;
  wire [335:0] img;
  // open drain: either party pulling low wins, pull-up otherwise
  wire sda = h_sda & (oe_n | sda_out);
  integer err_count = 0, n_compared = 0, seed = 32'hf00b, cyc = 0;
  logic [15:0] mdl [0:20];
  logic [15:0] dflt [0:20] = '{16'h0000, 16'h0a18, 16'h0007, 16'h0a18,
    16'h0007, 16'h59dd, 16'hc63e, 16'h651a, 16'he53e, 16'h4616, 16'hd33e,
    16'h4df3, 16'hea3e, 16'h5ee0, 16'hf93e, 16'h0093, 16'h92ba, 16'h12a5,
    16'h0004, 16'h10bd, 16'h0000};
  logic [6:0] dev;
  logic [4:0] ptr;
  logic ak;
  logic [15:0] d;
  amp_control_register_bank u_amp_control_register_bank (.clk(clk),
    .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out_r(sda_out),
    .sda_oe_n_r(oe_n), .adsel1(adsel1), .adsel2(adsel2),
    .status_in(status_in), .input_sel_r(in_sel), .amp_run_choice_r(run),
    .wake_request_r(wake), .amp_enabled_r(amp_en),
    .active_serial_cfg_r(ser), .active_pcm_fmt_r(pcm),
    .soft_reset_pulse_r(sr_p), .reg_write_pulse_r(wr_p),
    .reg_write_index_r(wr_i), .bus_busy_r(busy), .reg_image(img));
  i2c_host_model u_i2c_host_model (.clk(clk), .sda(sda), .scl(scl),
    .sda_drv(h_sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hung bus ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      print_verdict;
    end
  end
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string what, input [15:0] exp, input [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task open_at(input [4:0] a, input rd);
    ptr = a;
    u_i2c_host_model.start;
    u_i2c_host_model.wbyte({dev, 1'b0}, ak);
    chk("address ack", 16'h0001, {15'h0, ak});
    u_i2c_host_model.wbyte({3'h0, a}, ak);
    chk("pointer ack", 16'h0001, {15'h0, ak});
    if (rd) begin
      u_i2c_host_model.start;
      u_i2c_host_model.wbyte({dev, 1'b1}, ak);
      chk("read ack", 16'h0001, {15'h0, ak});
    end
  endtask
  // sends one pair and moves the model the way the bank should move
  task put_word(input [15:0] v);
    u_i2c_host_model.wbyte(v[15:8], ak);
    u_i2c_host_model.wbyte(v[7:0], ak);
    chk("data ack", 16'h0001, {15'h0, ak});
    if (ptr == 5'h00 && v[1]) foreach (mdl[i]) mdl[i] = dflt[i];
    else if (ptr == 5'h00) mdl[0] = v & 16'h0019;
    else if (ptr < 5'h15) mdl[ptr] = v;
    ptr++;
  endtask
  task wr_burst(input [4:0] a, input integer n);
    open_at(a, 1'b0);
    repeat (n) begin
      d = $random(seed);
      if (ptr == 5'h00) d[1] = 1'b0;
      put_word(d);
    end
    u_i2c_host_model.stop;
  endtask
  task rd_burst(input [4:0] a, input integer n);
    logic [7:0] hi, lo;
    logic [15:0] e;
    open_at(a, 1'b1);
    for (int k = 1; k <= n; k++) begin
      u_i2c_host_model.rbyte(hi, 1'b1);
      u_i2c_host_model.rbyte(lo, k < n);
      e = ptr < 5'h15 ? mdl[ptr] : (ptr == 5'h15 ? status_in : 16'h0000);
      chk("read word", e, {hi, lo});
      ptr++;
    end
    u_i2c_host_model.stop;
  endtask
  task chk_all;
    @(posedge clk);
    #1;
    for (int i = 0; i < 21; i++) chk("image", mdl[i], img[16*i +: 16]);
    chk("mode", {13'h0, mdl[0][4], mdl[0][3], mdl[0][0]},
      {13'h0, in_sel, run, wake});
    chk("amp on", {15'h0, mdl[0][0] & mdl[0][3]}, {15'h0, amp_en});
    chk("serial", mdl[0][4] ? mdl[3] : mdl[1], ser);
    chk("pcm", mdl[0][4] ? mdl[4] : mdl[2], pcm);
  endtask
  initial begin
    rst = 1'b1;
    adsel1 = $random(seed);
    adsel2 = $random(seed);
    status_in = $random(seed);
    foreach (mdl[i]) mdl[i] = dflt[i];
    dev = {5'h1b, adsel2, adsel1};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk_all;
    // long burst wraps past status and unmapped slots back to 00h
    wr_burst(5'h05, 32);
    chk_all;
    rd_burst(5'h00, 23);
    // every input, power and run combination, reserved bits set randomly
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d[4] = i[2];
      d[3] = i[1];
      d[1] = 1'b0;
      d[0] = i[0];
      open_at(5'h00, 1'b0);
      put_word(d);
      u_i2c_host_model.stop;
      chk_all;
      rd_burst(5'h00, 1);
    end
    // soft reset undoes earlier writes and clears its own bit
    open_at(5'h00, 1'b0);
    put_word(16'hffff);
    u_i2c_host_model.stop;
    chk_all;
    rd_burst(5'h00, 2);
    // a lone high byte must not be stored
    open_at(5'h13, 1'b0);
    u_i2c_host_model.wbyte(8'h5a, ak);
    u_i2c_host_model.stop;
    chk_all;
    // foreign address gets no answer
    u_i2c_host_model.start;
    u_i2c_host_model.wbyte({dev ^ 7'h01, 1'b0}, ak);
    chk("foreign ack", 16'h0000, {15'h0, ak});
    u_i2c_host_model.stop;
    // slow host and a fresh status word
    u_i2c_host_model.half = 10;
    status_in = $random(seed);
    wr_burst(5'h10, 3);
    rd_burst(5'h10, 6);
    chk_all;
    // mid-run reset must restore defaults and leave the bus usable
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    foreach (mdl[i]) mdl[i] = dflt[i];
    chk_all;
    rd_burst(5'h10, 2);
    print_verdict;
  end
endmodule // amp_control_register_bank_tb
